//--- hdl/cppp_pkg.sv
package cppp_pkg;

  localparam int NUM_OUTPUTS = 9;
  localparam int ADDR_W = 4;
  localparam int SEL_W = 4;
  localparam int AXI_AW = 8;

  localparam logic [7:0] CTRL_OFFS = 8'h00;
  localparam logic [7:0] CMD_OFFS = 8'h04;
  localparam logic [7:0] STATUS_OFFS = 8'h08;
  localparam logic [7:0] LOADED_OFFS = 8'h0C;

  localparam int CMD_ADDR_LSB = 0;
  localparam int CMD_SEL_LSB = 4;
  localparam int CMD_EN_BIT = 8;
  localparam int CMD_BCAST_BIT = 9;
  localparam int CMD_APPLY_BIT = 10;
  localparam int CMD_WRITE_BIT = 11;

  localparam int CTRL_DIS_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_INIT_BIT = 1;
  localparam int STAT_REFUSED_BIT = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int CLK_PERIOD_NS = 50;
  localparam int SETUP_NS = 100;
  localparam int STROBE_LOW_NS = 100;
  localparam int HOLD_NS = 100;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOW_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic write;
    logic apply;
    logic bcast;
    logic en;
    logic [SEL_W-1:0] sel;
    logic [ADDR_W-1:0] addr;
  } cppp_cmd_t;

  // Merges a bus write into an old word lane by lane.
  function automatic logic [31:0] strb_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return r;
  endfunction

endpackage

//--- hdl/cppp_axil_slave.sv
`timescale 1ns/100ps
`default_nettype none
module cppp_axil_slave (
  input wire logic clk,
  input wire logic rst,
  input wire logic [cppp_pkg::AXI_AW-1:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [cppp_pkg::AXI_AW-1:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  output logic wr_en,
  output logic [cppp_pkg::AXI_AW-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  output logic [cppp_pkg::AXI_AW-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);

  // Both halves held and no response pending: commit exactly once.
  assign wr_en = !s_axil_awready && !s_axil_wready && !s_axil_bvalid;
  assign rd_addr = s_axil_araddr;

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axil_awready <= 1'b1;
      s_axil_wready <= 1'b1;
    end else if (s_axil_bvalid && s_axil_bready) begin
      s_axil_awready <= 1'b1;
      s_axil_wready <= 1'b1;
    end else begin
      if (s_axil_awvalid && s_axil_awready) begin
        s_axil_awready <= 1'b0;
      end
      if (s_axil_wvalid && s_axil_wready) begin
        s_axil_wready <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_addr <= '0;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end else begin
      if (s_axil_awvalid && s_axil_awready) begin
        wr_addr <= s_axil_awaddr;
      end
      if (s_axil_wvalid && s_axil_wready) begin
        wr_data <= s_axil_wdata;
        wr_strb <= s_axil_wstrb;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axil_bvalid <= 1'b0;
      s_axil_bresp <= cppp_pkg::RESP_OKAY;
    end else if (wr_en) begin
      s_axil_bvalid <= 1'b1;
      s_axil_bresp <= wr_err ? cppp_pkg::RESP_SLVERR : cppp_pkg::RESP_OKAY;
    end else if (s_axil_bready) begin
      s_axil_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axil_arready <= 1'b1;
      s_axil_rvalid <= 1'b0;
      s_axil_rdata <= 32'h0000_0000;
      s_axil_rresp <= cppp_pkg::RESP_OKAY;
    end else if (s_axil_arvalid && s_axil_arready) begin
      s_axil_arready <= 1'b0;
      s_axil_rvalid <= 1'b1;
      s_axil_rdata <= rd_data;
      s_axil_rresp <= rd_err ? cppp_pkg::RESP_SLVERR : cppp_pkg::RESP_OKAY;
    end else if (s_axil_rvalid && s_axil_rready) begin
      s_axil_arready <= 1'b1;
      s_axil_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

//--- hdl/cppp_pin_seq.sv
`timescale 1ns/100ps
`default_nettype none
module cppp_pin_seq #(
  parameter int SETUP_CYC = cppp_pkg::SETUP_CYC,
  parameter int LOW_CYC = cppp_pkg::LOW_CYC,
  parameter int HOLD_CYC = cppp_pkg::HOLD_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire cppp_pkg::cppp_cmd_t cmd,
  output logic busy,
  output logic write_strobe_n,
  output logic [cppp_pkg::ADDR_W-1:0] output_address,
  output logic [cppp_pkg::SEL_W-1:0] input_select,
  output logic output_enable_bit,
  output logic apply_strobe_n,
  output logic serial_parallel_select,
  output logic serial_clock_n
);

  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_WLOW, ST_WHOLD, ST_ALOW, ST_AHOLD} cppp_seq_t;

  cppp_seq_t st_reg;
  cppp_seq_t st_next;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  cppp_pkg::cppp_cmd_t cmd_reg;
  cppp_pkg::cppp_cmd_t cmd_cur;

  assign cmd_cur = start ? cmd : cmd_reg;

  always_comb begin
    st_next = st_reg;
    cnt_next = (cnt_reg != 8'h00) ? cnt_reg - 8'h01 : 8'h00;
    case (st_reg)
      ST_IDLE: begin
        if (start && cmd.write) begin
          st_next = ST_SETUP;
          cnt_next = 8'(SETUP_CYC - 1);
        end else if (start) begin
          st_next = ST_ALOW;
          cnt_next = 8'(LOW_CYC - 1);
        end
      end
      ST_SETUP: begin
        if (cnt_reg == 8'h00) begin
          st_next = ST_WLOW;
          cnt_next = 8'(LOW_CYC - 1);
        end
      end
      ST_WLOW: begin
        if (cnt_reg == 8'h00) begin
          st_next = ST_WHOLD;
          cnt_next = 8'(HOLD_CYC - 1);
        end
      end
      ST_WHOLD: begin
        if (cnt_reg == 8'h00) begin
          st_next = cmd_reg.apply ? ST_ALOW : ST_IDLE;
          cnt_next = 8'(LOW_CYC - 1);
        end
      end
      ST_ALOW: begin
        if (cnt_reg == 8'h00) begin
          st_next = ST_AHOLD;
          cnt_next = 8'(HOLD_CYC - 1);
        end
      end
      ST_AHOLD: begin
        if (cnt_reg == 8'h00) begin
          st_next = ST_IDLE;
        end
      end
      default: begin
        st_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= ST_IDLE;
      cnt_reg <= 8'h00;
      busy <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      busy <= (st_next != ST_IDLE);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_reg <= '0;
      output_address <= '0;
      input_select <= '0;
      output_enable_bit <= 1'b0;
    end else if (start && st_reg == ST_IDLE) begin
      cmd_reg <= cmd;
      if (cmd.write) begin
        output_address <= cmd.addr;
        input_select <= cmd.sel;
        output_enable_bit <= cmd.en;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      write_strobe_n <= 1'b1;
      apply_strobe_n <= 1'b1;
      serial_parallel_select <= 1'b1;
      serial_clock_n <= 1'b1;
    end else begin
      write_strobe_n <= (st_next != ST_WLOW);
      apply_strobe_n <= (st_next != ST_ALOW);
      serial_parallel_select <= !(cmd_cur.bcast && cmd_cur.write &&
                                  (st_next == ST_SETUP || st_next == ST_WLOW || st_next == ST_WHOLD));
      serial_clock_n <= 1'b1;
    end
  end

  chk_par_levels: assert property (@(posedge clk) disable iff (rst)
    $fell(write_strobe_n) |-> apply_strobe_n && serial_clock_n)
    else $error("strobe fell without apply and serial clock high");
  chk_bcast_select: assert property (@(posedge clk) disable iff (rst)
    $fell(write_strobe_n) && !serial_parallel_select |-> $past(serial_parallel_select) == 1'b0)
    else $error("broadcast select not settled before strobe");
  chk_addr_setup: assert property (@(posedge clk) disable iff (rst)
    $fell(write_strobe_n) |-> output_address == $past(output_address, 2))
    else $error("address changed inside setup time");
  chk_data_hold: assert property (@(posedge clk) disable iff (rst)
    !write_strobe_n |=> $stable(input_select) && $stable(output_enable_bit) && $stable(output_address))
    else $error("data moved around the write strobe");
  chk_strobe_order: assert property (@(posedge clk) disable iff (rst)
    $fell(apply_strobe_n) |-> write_strobe_n && $past(write_strobe_n))
    else $error("apply overlaps write strobe");

endmodule
`default_nettype wire

//--- hdl/cppp_ctrl.sv
// Notes on behaviour
// - Before a parallel write, select, apply and serial clock are high.
// - A 4-bit output address is presented before the write edge.
// - Four input-select lines carry the input number with the address.
// - Several writes may precede one apply; all take effect together.
// - Controller writes every output after power-up before trusting the matrix.
// - Apply stays high until the whole first rank is loaded.
// - No write strobe line is shared between devices.
// - Broadcast: parallel-style write with select low and serial clock high.
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module cppp_ctrl #(
  parameter int NUM_OUTPUTS = cppp_pkg::NUM_OUTPUTS,
  parameter int SETUP_CYC = cppp_pkg::SETUP_CYC,
  parameter int LOW_CYC = cppp_pkg::LOW_CYC,
  parameter int HOLD_CYC = cppp_pkg::HOLD_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [cppp_pkg::AXI_AW-1:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [cppp_pkg::AXI_AW-1:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  output logic write_strobe_n,
  output logic [cppp_pkg::ADDR_W-1:0] output_address,
  output logic [cppp_pkg::SEL_W-1:0] input_select,
  output logic output_enable_bit,
  output logic apply_strobe_n,
  output logic serial_parallel_select,
  output logic serial_clock_n,
  output logic serial_data_in,
  output logic chip_select_n,
  output logic output_disable_reset_n
);

  logic wr_en;
  logic [cppp_pkg::AXI_AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic [cppp_pkg::AXI_AW-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;

  logic [31:0] ctrl_reg;
  logic [31:0] cmd_word;
  cppp_pkg::cppp_cmd_t cmd_new;
  cppp_pkg::cppp_cmd_t cmd_last_reg;
  logic [NUM_OUTPUTS-1:0] loaded_reg;
  logic [NUM_OUTPUTS-1:0] loaded_add;
  logic init_done;
  logic will_init;
  logic refused_reg;
  logic seq_busy;
  logic cmd_wr;
  logic cmd_bad;
  logic cmd_go;
  logic addr_ok;
  logic refused_clr;
  logic [31:0] clr_word;

  // Known register offsets; anything else answers with an error.
  function automatic logic addr_known(input logic [cppp_pkg::AXI_AW-1:0] a);
    logic [7:0] o;
    o = a[7:0];
    return (o == cppp_pkg::CTRL_OFFS) || (o == cppp_pkg::CMD_OFFS) ||
           (o == cppp_pkg::STATUS_OFFS) || (o == cppp_pkg::LOADED_OFFS);
  endfunction

  cppp_axil_slave u_bus (
    .clk(clk),
    .rst(rst),
    .s_axil_awaddr(s_axil_awaddr),
    .s_axil_awvalid(s_axil_awvalid),
    .s_axil_awready(s_axil_awready),
    .s_axil_wdata(s_axil_wdata),
    .s_axil_wstrb(s_axil_wstrb),
    .s_axil_wvalid(s_axil_wvalid),
    .s_axil_wready(s_axil_wready),
    .s_axil_bresp(s_axil_bresp),
    .s_axil_bvalid(s_axil_bvalid),
    .s_axil_bready(s_axil_bready),
    .s_axil_araddr(s_axil_araddr),
    .s_axil_arvalid(s_axil_arvalid),
    .s_axil_arready(s_axil_arready),
    .s_axil_rdata(s_axil_rdata),
    .s_axil_rresp(s_axil_rresp),
    .s_axil_rvalid(s_axil_rvalid),
    .s_axil_rready(s_axil_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  assign wr_err = !addr_known(wr_addr);
  assign rd_err = !addr_known(rd_addr);

  always_comb begin
    rd_data = 32'h0000_0000;
    case (rd_addr[7:0])
      cppp_pkg::CTRL_OFFS: begin
        rd_data = ctrl_reg;
      end
      cppp_pkg::CMD_OFFS: begin
        rd_data = 32'(cmd_last_reg);
      end
      cppp_pkg::STATUS_OFFS: begin
        rd_data[cppp_pkg::STAT_BUSY_BIT] = seq_busy;
        rd_data[cppp_pkg::STAT_INIT_BIT] = init_done;
        rd_data[cppp_pkg::STAT_REFUSED_BIT] = refused_reg;
      end
      cppp_pkg::LOADED_OFFS: begin
        rd_data = 32'(loaded_reg);
      end
      default: begin
        rd_data = 32'h0000_0000;
      end
    endcase
  end

  // Only the disable bit of the control word is implemented.
  function automatic logic [31:0] strb_merge_ctrl(input logic [31:0] o, input logic [31:0] n,
                                                  input logic [3:0] s);
    logic [31:0] m;
    m = cppp_pkg::strb_merge(o, n, s);
    return {31'h0000_0000, m[cppp_pkg::CTRL_DIS_BIT]};
  endfunction

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= cppp_pkg::CTRL_RESET;
    end else if (wr_en && wr_addr[7:0] == cppp_pkg::CTRL_OFFS) begin
      ctrl_reg <= strb_merge_ctrl(ctrl_reg, wr_data, wr_strb);
    end
  end

  // A command word is decoded from the written lanes only.
  assign cmd_word = cppp_pkg::strb_merge(32'h0000_0000, wr_data, wr_strb);
  always_comb begin
    cmd_new.addr = cmd_word[cppp_pkg::CMD_ADDR_LSB +: cppp_pkg::ADDR_W];
    cmd_new.sel = cmd_word[cppp_pkg::CMD_SEL_LSB +: cppp_pkg::SEL_W];
    cmd_new.en = cmd_word[cppp_pkg::CMD_EN_BIT];
    cmd_new.bcast = cmd_word[cppp_pkg::CMD_BCAST_BIT];
    cmd_new.apply = cmd_word[cppp_pkg::CMD_APPLY_BIT];
    cmd_new.write = cmd_word[cppp_pkg::CMD_WRITE_BIT];
  end

  assign cmd_wr = wr_en && wr_addr[7:0] == cppp_pkg::CMD_OFFS;
  assign addr_ok = 32'(cmd_new.addr) < NUM_OUTPUTS;

  // outputs the pending write will load.
  always_comb begin
    loaded_add = '0;
    if (cmd_new.write && cmd_new.bcast) begin
      loaded_add = '1;
    end else if (cmd_new.write && addr_ok) begin
      loaded_add[cmd_new.addr] = 1'b1;
    end
  end

  assign init_done = &loaded_reg;
  assign will_init = &(loaded_reg | loaded_add);

  // refuse bad address, early apply, busy, or a command with neither write nor apply.
  assign cmd_bad = seq_busy || !(cmd_new.write || cmd_new.apply) ||
                   (cmd_new.write && !cmd_new.bcast && !addr_ok) ||
                   (cmd_new.apply && !will_init);
  assign cmd_go = cmd_wr && !cmd_bad;

  // track which first-rank latches hold chosen values.
  always_ff @(posedge clk) begin
    if (rst) begin
      loaded_reg <= '0;
    end else if (cmd_go) begin
      loaded_reg <= loaded_reg | loaded_add;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_last_reg <= '0;
    end else if (cmd_go) begin
      cmd_last_reg <= cmd_new;
    end
  end

  // A refusal in the cycle of a clear still sets the flag.
  assign clr_word = cppp_pkg::strb_merge(32'h0000_0000, wr_data, wr_strb);
  assign refused_clr = wr_en && wr_addr[7:0] == cppp_pkg::STATUS_OFFS &&
                       clr_word[cppp_pkg::STAT_REFUSED_BIT];
  always_ff @(posedge clk) begin
    if (rst) begin
      refused_reg <= 1'b0;
    end else if (cmd_wr && cmd_bad) begin
      refused_reg <= 1'b1;
    end else if (refused_clr) begin
      refused_reg <= 1'b0;
    end
  end

  // one command drives a whole strobe sequence.
  cppp_pin_seq #(
    .SETUP_CYC(SETUP_CYC),
    .LOW_CYC(LOW_CYC),
    .HOLD_CYC(HOLD_CYC)
  ) u_seq (
    .clk(clk),
    .rst(rst),
    .start(cmd_go),
    .cmd(cmd_new),
    .busy(seq_busy),
    .write_strobe_n(write_strobe_n),
    .output_address(output_address),
    .input_select(input_select),
    .output_enable_bit(output_enable_bit),
    .apply_strobe_n(apply_strobe_n),
    .serial_parallel_select(serial_parallel_select),
    .serial_clock_n(serial_clock_n)
  );

  // this controller owns a dedicated strobe; serial port stays idle.
  always_ff @(posedge clk) begin
    if (rst) begin
      chip_select_n <= 1'b1;
      serial_data_in <= 1'b0;
    end else begin
      chip_select_n <= 1'b1;
      serial_data_in <= 1'b0;
    end
  end

  // Outputs stay disabled from reset until software clears the bit.
  always_ff @(posedge clk) begin
    if (rst) begin
      output_disable_reset_n <= 1'b0;
    end else begin
      output_disable_reset_n <= !ctrl_reg[cppp_pkg::CTRL_DIS_BIT];
    end
  end

  chk_apply_loaded: assert property (@(posedge clk) disable iff (rst)
    $fell(apply_strobe_n) |-> init_done)
    else $error("apply driven before first rank loaded");
  chk_addr_valid: assert property (@(posedge clk) disable iff (rst)
    $fell(write_strobe_n) && serial_parallel_select |-> 32'(output_address) < NUM_OUTPUTS)
    else $error("parallel write to nonexistent output");
  chk_bcast_fill: assert property (@(posedge clk) disable iff (rst)
    cmd_go && cmd_new.write && cmd_new.bcast |=> init_done)
    else $error("broadcast did not mark all outputs loaded");
  chk_refuse_busy: assert property (@(posedge clk) disable iff (rst)
    cmd_wr && seq_busy |=> refused_reg && $stable(cmd_last_reg))
    else $error("command accepted while busy");
  chk_disable_pin: assert property (@(posedge clk) disable iff (rst)
    ctrl_reg[cppp_pkg::CTRL_DIS_BIT] |=> !output_disable_reset_n)
    else $error("disable bit not reflected on pin");
  chk_go_strobe: assert property (@(posedge clk) disable iff (rst)
    cmd_go && cmd_new.write |=> seq_busy && write_strobe_n && apply_strobe_n)
    else $error("strobe not high at start of write");
  chk_apply_held: assert property (@(posedge clk) disable iff (rst)
    !init_done |-> apply_strobe_n)
    else $error("apply low while first rank not loaded");
  chk_refused_set: assert property (@(posedge clk) disable iff (rst)
    cmd_wr && cmd_bad |=> refused_reg)
    else $error("refused command did not set the flag");
  chk_refuse_quiet: assert property (@(posedge clk) disable iff (rst)
    cmd_wr && cmd_bad |=> $stable(loaded_reg) && $stable(cmd_last_reg) && $stable(output_address))
    else $error("refused command changed state");

  cov_bcast: cover property (@(posedge clk) disable iff (rst)
    $fell(write_strobe_n) && !serial_parallel_select);
  cov_parallel: cover property (@(posedge clk) disable iff (rst)
    $fell(write_strobe_n) && serial_parallel_select);
  cov_apply: cover property (@(posedge clk) disable iff (rst)
    $fell(apply_strobe_n));
  cov_refused: cover property (@(posedge clk) disable iff (rst)
    $rose(refused_reg));

endmodule
`default_nettype wire

//--- tb/cppp_dev_model.sv
`timescale 1ns/100ps
`default_nettype none
module cppp_dev_model (
  input wire logic write_strobe_n,
  input wire logic [3:0] output_address,
  input wire logic [3:0] input_select,
  input wire logic output_enable_bit,
  input wire logic apply_strobe_n,
  input wire logic serial_parallel_select,
  input wire logic serial_clock_n,
  input wire logic output_disable_reset_n,
  output logic [44:0] first_q,
  output logic [44:0] route_q,
  output logic [8:0] live_q
);
  // no power-up value, no bad slot, chip select ignored.
  always @(negedge write_strobe_n) begin
    for (int i = 0; i < 9; i++) begin
      if (serial_parallel_select ? output_address == 4'(i) : serial_clock_n) begin
        first_q[5*i +: 5] <= {output_enable_bit, input_select};
      end
    end
  end
  always_latch begin
    if (!apply_strobe_n) begin
      route_q <= first_q;
    end
  end
  always_comb begin
    for (int i = 0; i < 9; i++) begin
      live_q[i] = output_disable_reset_n & route_q[5*i+4];
    end
  end
endmodule
`default_nettype wire

//--- tb/test_crosspoint_parallel_program_port.sv
`timescale 1ns/100ps
`default_nettype none
module test_crosspoint_parallel_program_port;
  typedef struct {
    logic [31:0] cmd;
    int slot;
    logic [4:0] f;
    logic [4:0] r;
    logic rf;
  } cppp_row_t;
  localparam logic [7:0] ST = cppp_pkg::STATUS_OFFS;
  localparam logic [44:0] FIN = {5'h0F, 5'h13, 5'h13, 5'h19, 5'h13, 5'h13, 5'h17, 5'h13, 5'h13};
  cppp_row_t rows [7] = '{'{32'h400, 0, 5'h13, 5'h13, 0}, '{32'h972, 2, 5'h17, 5'h13, 0},
    '{32'h8F8, 8, 5'h0F, 5'h13, 0}, '{32'h400, 2, 5'h17, 5'h17, 0}, '{32'hD95, 5, 5'h19, 5'h19, 0},
    '{32'h819, 8, 5'h0F, 5'h0F, 1}, '{32'h000, 5, 5'h19, 5'h19, 1}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, applies = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, bpins;
  logic write_strobe_n, output_enable_bit, apply_strobe_n, serial_parallel_select;
  logic serial_clock_n, serial_data_in, chip_select_n, output_disable_reset_n;
  logic [3:0] output_address, input_select;
  logic [44:0] first_q, route_q;
  logic [8:0] live_q;
  int errors = 0, checked = 0;

  cppp_ctrl dut_u (.clk, .rst, .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid), .s_axil_awready(awready),
    .s_axil_wdata(wdata), .s_axil_wstrb(4'hF), .s_axil_wvalid(wvalid), .s_axil_wready(wready),
    .s_axil_bresp(bresp), .s_axil_bvalid(bvalid), .s_axil_bready(bready), .s_axil_araddr(araddr),
    .s_axil_arvalid(arvalid), .s_axil_arready(arready), .s_axil_rdata(rdata), .s_axil_rresp(rresp),
    .s_axil_rvalid(rvalid), .s_axil_rready(rready), .write_strobe_n, .output_address, .input_select,
    .output_enable_bit, .apply_strobe_n, .serial_parallel_select, .serial_clock_n, .serial_data_in,
    .chip_select_n, .output_disable_reset_n);
  cppp_dev_model dev_u (.write_strobe_n, .output_address, .input_select, .output_enable_bit,
    .apply_strobe_n, .serial_parallel_select, .serial_clock_n, .output_disable_reset_n, .first_q,
    .route_q, .live_q);

  always #25 clk = ~clk;
  always @(negedge apply_strobe_n) applies <= applies + 8'h01;
  always @(negedge write_strobe_n) bpins <= {serial_parallel_select, serial_clock_n};

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge clk);
      ta = ta | awready;
      tw = tw | wready;
      awvalid <= !ta;
      wvalid <= !tw;
    end
    while (!bvalid) @(posedge clk);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic chk(input string n, input logic [44:0] e, input logic [44:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cmd(input logic [31:0] c);
    logic [31:0] s;
    logic [1:0] r;
    wr(cppp_pkg::CMD_OFFS, c, r);
    s = 32'h1;
    while (s[0] !== 1'b0) rd(ST, s, r);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    errors++;
    end_sim;
  end

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("idle pins", 5'h1F, {write_strobe_n, apply_strobe_n, serial_parallel_select, serial_clock_n, chip_select_n});
    chk("disable pin", 0, output_disable_reset_n);
    chk("serial data idle", 0, serial_data_in);
    rd(cppp_pkg::CTRL_OFFS, d, r);
    chk("ctrl reset", 1, d);
    rd(8'h10, d, r);
    chk("unmapped resp", 2'h2, r);
    $display("reset test done");
    cmd(32'h400);
    rd(ST, d, r);
    chk("early apply refused", 1, d[2]);
    chk("apply pulses", 0, applies);
    wr(ST, 32'h4, r);
    cmd(32'hB30);
    chk("broadcast rank", {9{5'h13}}, first_q);
    chk("broadcast pins", 2'b01, bpins);
    chk("broadcast held", 0, applies);
    wr(cppp_pkg::LOADED_OFFS, 32'h0, r);
    rd(cppp_pkg::LOADED_OFFS, d, r);
    chk("loaded mask", 32'h1FF, d);
    rd(ST, d, r);
    chk("init flag", 1, d[1]);
    $display("broadcast test done");
    foreach (rows[i]) begin
      cmd(rows[i].cmd);
      rd(ST, d, r);
      chk("refused", rows[i].rf, d[2]);
      chk("first rank", rows[i].f, first_q[5*rows[i].slot +: 5]);
      chk("matrix", rows[i].r, route_q[5*rows[i].slot +: 5]);
      wr(ST, 32'h4, r);
    end
    chk("others kept", FIN, route_q);
    $display("row tests done");
    wr(cppp_pkg::CMD_OFFS, 32'hD95, r);
    cmd(32'h8F1);
    rd(ST, d, r);
    chk("busy refused", 1, d[2]);
    chk("busy kept", 5'h13, first_q[9:5]);
    rd(cppp_pkg::CMD_OFFS, d, r);
    chk("last command", 32'hD95, d);
    wr(ST, 32'h4, r);
    $display("busy test done");
    wr(cppp_pkg::CTRL_OFFS, 32'h0, r);
    repeat (2) @(posedge clk);
    chk("live outputs", 9'h0FF, live_q);
    wr(cppp_pkg::CTRL_OFFS, 32'h1, r);
    repeat (2) @(posedge clk);
    chk("disabled", 0, live_q);
    chk("latches kept", FIN, route_q);
    $display("disable test done");
    end_sim;
  end
endmodule
`default_nettype wire
